// ---- hw/rscm_radio_ctrl.sv ----
// Serial configuration port and mode decoder of the radio transceiver.
// Assumes serial pins and mode pins arrive asynchronously; reference select is a config register bit.
// What this block does
// - Load addressed register on strobe rising edge
// - Strobe high: ignore data and clock
// - Sixteen-bit words with two-bit address
// - Sample data on shift clock rise, strobe low
// - Chip inactive forces standby, rest powered down
// - Active: receive-select picks receive or transmit
// - New frequency register value retunes oscillator
// - TDD mode offsets LO by IF in receive only
// - Receive mode drives sliced data out
// - Transmit opens loop, modulates from data
// - Reference either frequency, divider chosen accordingly
// - MSB first, 14 data then 2 address
// - Standby keeps registers, accepts writes
// - No error checking on loaded words
module rscm_radio_ctrl
  import rscm_pkg::*;
(
  input  wire logic              clk,          // 10 MHz system clock
  input  wire logic              srst,         // Synchronous reset, high
  input  wire rscm_serial_t      serialIn,     // Strobe, data, shift clock pins
  input  wire logic              chipActive,   // chip_active_select pin
  input  wire logic              receiveSel,   // receive_select pin
  input  wire logic              slicedData,   // Data slicer output
  input  wire logic              txData,       // Filtered transmit data
  output rscm_mode_t             modeOut,      // Decoded operating mode
  output rscm_radio_t            radioCtl,     // Synthesizer and path controls
  output logic                   rxDataOut,    // Receive data to baseband
  output logic                   txModOut,     // Oscillator modulation drive
  output logic [DATA_W-1:0]      freqWord      // Frequency register contents
);

  // Three-stage synchronisers on every asynchronous pin
  logic [SYNC_W-1:0] strbSync_q, datSync_q, sclkSync_q, actSync_q, rxsSync_q;
  always_ff @(posedge clk) begin
    strbSync_q <= {strbSync_q[SYNC_W-2:0], serialIn.loadStrobe};
    datSync_q  <= {datSync_q[SYNC_W-2:0], serialIn.serData};
    sclkSync_q <= {sclkSync_q[SYNC_W-2:0], serialIn.shiftClk};
    actSync_q  <= {actSync_q[SYNC_W-2:0], chipActive};
    rxsSync_q  <= {rxsSync_q[SYNC_W-2:0], receiveSel};
  end

  // Filtered levels change only once stages two and three agree
  logic strb_q, dat_q, sclk_q, act_q, rxs_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      strb_q <= 1'b1;
      dat_q  <= 1'b0;
      sclk_q <= 1'b0;
      act_q  <= 1'b0;
      rxs_q  <= 1'b0;
    end else begin
      if (strbSync_q[1] == strbSync_q[2]) strb_q <= strbSync_q[2];
      if (datSync_q[1] == datSync_q[2])   dat_q  <= datSync_q[2];
      if (sclkSync_q[1] == sclkSync_q[2]) sclk_q <= sclkSync_q[2];
      if (actSync_q[1] == actSync_q[2])   act_q  <= actSync_q[2];
      if (rxsSync_q[1] == rxsSync_q[2])   rxs_q  <= rxsSync_q[2];
    end
  end

  // Edge detection on the filtered strobe and shift clock
  logic strbPrev_q, sclkPrev_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      strbPrev_q <= 1'b1;
      sclkPrev_q <= 1'b0;
    end else begin
      strbPrev_q <= strb_q;
      sclkPrev_q <= sclk_q;
    end
  end
  // Strobe reset high so no false load at start-up
  wire strbRise  = strb_q & ~strbPrev_q;
  wire shiftTake = sclk_q & ~sclkPrev_q & ~strb_q;

  // Shift register, MSB first; frozen while strobe is high
  logic [WORD_W-1:0] shift_q, shift_d;
  assign shift_d = shiftTake ? {shift_q[WORD_W-2:0], dat_q} : shift_q;
  always_ff @(posedge clk) begin
    if (srst) shift_q <= '0;
    else      shift_q <= shift_d;
  end

  // Word split: leading data field, trailing address field
  wire [DATA_W-1:0] wordData = shift_q[WORD_W-1:ADDR_W];
  wire [ADDR_W-1:0] wordAddr = shift_q[ADDR_W-1:0];

  // Register bank; loads in any mode, no checks on content
  logic [DATA_W-1:0] regs_q [NUM_REGS];
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < NUM_REGS; i++) regs_q[i] <= REG_RST;
    end else if (strbRise) begin
      regs_q[wordAddr] <= wordData;
    end
  end

  // Mode decode from the parallel pins
  rscm_mode_t mode_d, mode_q;
  assign mode_d = !act_q ? RSCM_STANDBY :
                  (rxs_q ? RSCM_RECEIVE : RSCM_TRANSMIT);

  // Configuration fields
  wire [DATA_W-1:0] cfgReg  = regs_q[ADDR_CFG];
  wire              tddOn   = cfgReg[CFG_TDD_BIT];
  wire              refHigh = cfgReg[CFG_REF2_BIT];

  // LO tuning: frequency word, shifted by the IF in TDD receive
  wire [DATA_W-1:0] baseTune = regs_q[ADDR_FREQ];
  wire [DATA_W-1:0] tune_d   = (tddOn && mode_d == RSCM_RECEIVE) ?
                               DATA_W'(baseTune - IF_STEPS) : baseTune;
  wire [3:0]        refDiv_d = refHigh ? REF_DIV_HI : REF_DIV_LO;

  // Radio path controls: tuning and divider from registers, path bits from the mode
  rscm_radio_t radio_d;
  assign radio_d.loTune   = tune_d;
  assign radio_d.refDiv   = refDiv_d;
  assign radio_d.loopOpen = (mode_d == RSCM_TRANSMIT);
  assign radio_d.rxPath   = (mode_d == RSCM_RECEIVE);
  assign radio_d.powered  = (mode_d != RSCM_STANDBY);

  // Data paths gated by mode; idle low otherwise
  wire rxData_d = radio_d.rxPath & slicedData;
  wire txMod_d  = radio_d.loopOpen & txData;

  // Registered outputs; the host must allow lock time after changes
  always_ff @(posedge clk) begin
    if (srst) begin
      mode_q    <= RSCM_STANDBY;
      radioCtl  <= '0;
      rxDataOut <= 1'b0;
      txModOut  <= 1'b0;
      freqWord  <= REG_RST;
    end else begin
      mode_q    <= mode_d;
      radioCtl  <= radio_d;
      rxDataOut <= rxData_d;
      txModOut  <= txMod_d;
      freqWord  <= baseTune;
    end
  end
  assign modeOut = mode_q;

endmodule : rscm_radio_ctrl

// ---- shared/rscm_pkg.sv ----
// Constants and types for the radio serial control and mode logic.
// Assumes a 10 MHz system clock; serial pins and reference are asynchronous.
package rscm_pkg;
  localparam int WORD_W    = 16;
  localparam int DATA_W    = 14;
  localparam int ADDR_W    = 2;
  localparam int NUM_REGS  = 4;
  localparam int SYNC_W    = 3;
  localparam logic [ADDR_W-1:0] ADDR_FREQ = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_CFG  = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_REFD = 2'h2;
  localparam logic [ADDR_W-1:0] ADDR_TEST = 2'h3;
  localparam logic [DATA_W-1:0] REG_RST   = 14'h0000;
  // Config register fields
  localparam int CFG_TDD_BIT  = 0;
  localparam int CFG_REF2_BIT = 1;
  // LO offset by the IF: 1.024 MHz over 512 kHz steps
  localparam int IF_KHZ   = 1024;
  localparam int STEP_KHZ = 512;
  localparam logic [DATA_W-1:0] IF_STEPS = DATA_W'(IF_KHZ / STEP_KHZ);
  // Reference divide ratios to the 1.024 MHz comparison rate
  localparam int REF_LO_KHZ = 6144;
  localparam int REF_HI_KHZ = 12288;
  localparam logic [3:0] REF_DIV_LO = 4'(REF_LO_KHZ / IF_KHZ);
  localparam logic [3:0] REF_DIV_HI = 4'(REF_HI_KHZ / IF_KHZ);

  typedef enum logic [1:0] {
    RSCM_STANDBY  = 2'h0,
    RSCM_RECEIVE  = 2'h1,
    RSCM_TRANSMIT = 2'h3
  } rscm_mode_t;

  typedef struct packed {
    logic loadStrobe;
    logic serData;
    logic shiftClk;
  } rscm_serial_t;

  typedef struct packed {
    logic [DATA_W-1:0] loTune;
    logic [3:0]        refDiv;
    logic              loopOpen;
    logic              rxPath;
    logic              powered;
  } rscm_radio_t;
endpackage : rscm_pkg

// ---- testbench/rscm_host_model.sv ----
// Host model: shifts whole words MSB first, link clock 800 ns.
// Assumes the 100 ns system clock paces the link.
module rscm_host_model
  import rscm_pkg::*;
(
  input  wire logic   clk,     // System clock
  output rscm_serial_t serialIn // Serial pins
);
  initial serialIn = 3'b100; // Strobe high, link clock still
  // Data held four cycles around each rise for the synchronisers
  task automatic send(input logic [WORD_W-1:0] w);
    for (int i = WORD_W - 1; i >= 0; i--) begin
      serialIn.loadStrobe <= 1'b0;
      serialIn.serData    <= w[i];
      repeat (4) @(posedge clk);
      serialIn.shiftClk <= 1'b1;
      repeat (4) @(posedge clk);
      serialIn.shiftClk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    serialIn.loadStrobe <= 1'b1;
    serialIn.serData    <= ~w[0]; // No stale bit on a released line
  endtask : send
  // Clock pulses with strobe high, then an empty strobe cycle
  task automatic noise;
    serialIn.serData <= 1'b0;
    repeat (2) begin
      repeat (4) @(posedge clk);
      serialIn.shiftClk <= 1'b1;
      repeat (4) @(posedge clk);
      serialIn.shiftClk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    serialIn.loadStrobe <= 1'b0;
    repeat (4) @(posedge clk);
    serialIn.loadStrobe <= 1'b1;
  endtask : noise
endmodule : rscm_host_model

// ---- testbench/rscm_radio_ctrl_bench.sv ----
// Bench for the radio control block: modes, serial loads, offset.
// Host model drives the serial pins; checker is bound in.
module rscm_radio_ctrl_bench
  import rscm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, srst = 1'b1, chipActive = 1'b0, receiveSel = 1'b0;
  logic slicedData = 1'b0, txData = 1'b0, rxDataOut, txModOut;
  rscm_serial_t serialIn;
  rscm_mode_t modeOut;
  rscm_radio_t radioCtl;
  logic [DATA_W-1:0] freqWord;
  int err_count = 0, check_count = 0;
  always #50 clk = ~clk;
  rscm_host_model host (.clk, .serialIn);
  rscm_radio_ctrl DUT (.clk, .srst, .serialIn, .chipActive, .receiveSel, .slicedData,
    .txData, .modeOut, .radioCtl, .rxDataOut, .txModOut, .freqWord);
  task automatic chk(input logic [13:0] seen, input logic [13:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk
  // Mode table, with both data inputs high to expose the gating
  task automatic t_modes;
    for (int i = 0; i < 3; i++) begin
      chipActive <= (i != 0);
      receiveSel <= (i != 2);
      repeat (10) @(posedge clk);
      chk(modeOut, (i == 0) ? RSCM_STANDBY : (i == 1) ? RSCM_RECEIVE : RSCM_TRANSMIT);
      chk({rxDataOut, txModOut, radioCtl.loopOpen}, {i == 1, i == 2, i == 2});
    end
    $display("modes done");
  endtask : t_modes
  task automatic send(input logic [13:0] d, input logic [1:0] a);
    host.send({d, a});
    repeat (8) @(posedge clk);
  endtask : send
  // Writes in standby, a hop, a foreign address, then the offset
  task automatic t_load;
    chipActive <= 1'b0;
    send(14'h2A5B, ADDR_FREQ);
    chk(freqWord, 14'h2A5B);
    send(14'h01C3, ADDR_FREQ);
    chk(freqWord, 14'h01C3);
    send(14'h3FFF, ADDR_TEST);
    chk(freqWord, 14'h01C3);
    chipActive <= 1'b1;
    receiveSel <= 1'b1;
    send(14'h0003, ADDR_CFG);
    chk(radioCtl.refDiv, REF_DIV_HI);
    chk(radioCtl.loTune, 14'h01C3 - IF_STEPS);
    receiveSel <= 1'b0;
    repeat (10) @(posedge clk);
    chk(radioCtl.loTune, 14'h01C3);
    // Shifts with strobe high would turn 1234 into 08D0
    send(14'h1234, ADDR_FREQ);
    chk(freqWord, 14'h1234);
    host.noise();
    repeat (8) @(posedge clk);
    chk(freqWord, 14'h1234);
    send(14'h0000, ADDR_CFG);
    chk(radioCtl.refDiv, REF_DIV_LO);
    $display("loads done");
  endtask : t_load
  task automatic end_sim;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim
  initial begin
    repeat (4) @(posedge clk);
    srst       <= 1'b0;
    slicedData <= 1'b1;
    txData     <= 1'b1;
    repeat (5) @(posedge clk);
    t_modes();
    t_load();
    end_sim();
  end
  // Run needs about 1000 cycles
  initial begin
    #500000;
    err_count++;
    end_sim();
  end
endmodule : rscm_radio_ctrl_bench

// ---- testbench/rscm_radio_ctrl_chk.sv ----
// Checker for the radio control block: mode decode, gating, loads.
// Sees only top-level ports; bound in below.
module rscm_radio_ctrl_chk
  import rscm_pkg::*;
(
  input wire logic              clk,        // Clock
  input wire logic              srst,       // Reset
  input wire rscm_serial_t      serialIn,   // Serial pins
  input wire logic              chipActive, // Active pin
  input wire logic              receiveSel, // Rx select
  input wire logic              slicedData, // Slicer in
  input wire rscm_mode_t        modeOut,    // Mode
  input wire rscm_radio_t       radioCtl,   // Controls
  input wire logic              rxDataOut,  // Rx data
  input wire logic              txModOut,   // Tx drive
  input wire logic [DATA_W-1:0] freqWord    // Freq reg
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Pins pass three sync stages, so allow seven cycles of settling
  reset_mode_a: assert property ($fell(srst) |-> modeOut == RSCM_STANDBY)
    else $error("mode not standby at reset release");
  standby_mode_a: assert property ((!chipActive)[*7] |-> modeOut == RSCM_STANDBY)
    else $error("inactive chip not in standby");
  rx_mode_a: assert property ((chipActive && receiveSel)[*7] |-> modeOut == RSCM_RECEIVE)
    else $error("receive mode not decoded");
  tx_mode_a: assert property ((chipActive && !receiveSel)[*7] |-> modeOut == RSCM_TRANSMIT)
    else $error("transmit mode not decoded");
  power_off_a: assert property ((modeOut == RSCM_STANDBY)[*3] |-> !radioCtl.powered)
    else $error("powered in standby");
  rx_pass_a: assert property ((modeOut == RSCM_RECEIVE && slicedData)[*3] |-> rxDataOut)
    else $error("sliced data not passed");
  tx_gate_a: assert property ((modeOut != RSCM_TRANSMIT)[*3] |-> !txModOut)
    else $error("modulation outside transmit");
  loop_open_a: assert property ((modeOut == RSCM_TRANSMIT)[*3] |-> radioCtl.loopOpen)
    else $error("loop closed in transmit");
  strobe_hold_a: assert property (serialIn.loadStrobe[*8] |=> $stable(freqWord))
    else $error("register moved with strobe high");
  cover property (modeOut == RSCM_RECEIVE);
  cover property (modeOut == RSCM_TRANSMIT);
  cover property ($changed(freqWord));
endmodule : rscm_radio_ctrl_chk
bind rscm_radio_ctrl rscm_radio_ctrl_chk chk_i (.clk, .srst, .serialIn, .chipActive, .receiveSel,
  .slicedData, .modeOut, .radioCtl, .rxDataOut, .txModOut, .freqWord);
